// file: dslc_pkg.sv
// Purpose: shared constants and types of the block
// Assumes: registers are 8 bits wide, one per aligned 32-bit bus word
// Notes: register indices are word numbers; byte address is four times the index
package dslc_pkg;

    // ================
    // bus geometry
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned IDX_W = 10;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_W = 8;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ================
    // register indices
    localparam logic [IDX_W-1:0] IDX_DITHER_CONTROL = 10'h09D;
    localparam logic [IDX_W-1:0] IDX_SAMPLE_LSB_CONTROL = 10'h160;
    localparam logic [IDX_W-1:0] IDX_SERIAL_LINK_ENABLE = 10'h200;
    localparam logic [IDX_W-1:0] IDX_SERIAL_LINK_OUTPUT_MODE = 10'h201;
    localparam logic [IDX_W-1:0] IDX_FRAMES_PER_MULTIFRAME_LESS_ONE = 10'h202;
    localparam logic [IDX_W-1:0] IDX_SUPPORT_CONTROL = 10'h210;
    localparam logic [IDX_W-1:0] IDX_LINK_STATUS = 10'h211;

    // ================
    // field positions
    localparam int unsigned BIT_DITHER_ENABLE = 0;
    localparam int unsigned BIT_DITHER_AMPLITUDE_SELECT = 1;
    localparam int unsigned BIT_ROUNDING_ERROR_SELECT = 2;
    localparam int unsigned BIT_TIMESTAMP_INSERT_ENABLE = 0;
    localparam int unsigned BIT_SERIAL_LINK_ENABLE = 0;
    localparam int unsigned MODE_W = 6;
    localparam int unsigned BIT_CAL_ENABLE = 0;
    localparam int unsigned BIT_TIMESTAMP_RECEIVER_ENABLE = 1;
    localparam int unsigned BIT_STAT_RUNNING = 0;
    localparam int unsigned BIT_STAT_WIDE_CODE = 1;

    // ================
    // reset values
    localparam logic [2:0] RST_DITHER_CONTROL = 3'h0;
    localparam logic RST_TIMESTAMP_INSERT_ENABLE = 1'b0;
    localparam logic RST_SERIAL_LINK_ENABLE = 1'b1;
    localparam logic [MODE_W-1:0] RST_SERIAL_LINK_OUTPUT_MODE = 6'h00;
    localparam logic [7:0] RST_FRAMES_PER_MULTIFRAME_LESS_ONE = 8'h1F;
    localparam logic RST_CAL_ENABLE = 1'b0;
    localparam logic RST_TIMESTAMP_RECEIVER_ENABLE = 1'b0;

    // ================
    // timing and mode decode
    localparam int unsigned SYNC_STAGES = 2;
    localparam int unsigned K_W = 9;
    // output modes at or above this code use the 64b/66b link layer
    localparam logic [MODE_W-1:0] MODE_WIDE_CODE_FIRST = 6'h10;
    localparam logic [K_W-1:0] WIDE_K_BASE = 9'h100;

    // ================
    // carriers
    typedef struct packed {
        logic [ADDR_W-1:0] awaddr;
        logic awvalid;
        logic [DATA_W-1:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [ADDR_W-1:0] araddr;
        logic arvalid;
        logic rready;
    } dslc_axil_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [DATA_W-1:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } dslc_axil_rsp_s;

    typedef struct packed {
        logic wr_en;
        logic [IDX_W-1:0] wr_idx;
        logic [REG_W-1:0] wr_data;
        logic [IDX_W-1:0] rd_idx;
    } dslc_reg_req_s;

endpackage

// file: dslc_ts_delay.sv
// Purpose: fixed-depth delay line for a narrow signal
// Assumes: DEPTH of zero passes the input straight through
// Notes: storage is a chain of flip-flops, cleared by reset
`timescale 1ns/10ps
`default_nettype none
module dslc_ts_delay
    import dslc_pkg::*;
#(
    parameter int unsigned DEPTH = 6,
    parameter int unsigned WIDTH = 1
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    // ================
    // delay chain
    generate
        if (DEPTH == 0) begin : g_pass
            assign dout = din;
        end else begin : g_chain
            logic [WIDTH-1:0] stage_q [DEPTH];
            for (genvar i = 0; i < DEPTH; i++) begin : g_stage
                always_ff @(posedge clk) begin
                    if (sys_rst) begin
                        stage_q[i] <= '0;
                    end else if (i == 0) begin
                        stage_q[i] <= din;
                    end else begin
                        stage_q[i] <= stage_q[(i == 0) ? 0 : i-1];
                    end
                end
            end
            assign dout = stage_q[DEPTH-1];
        end
    endgenerate

endmodule
`default_nettype wire

// file: dslc_axil_slave.sv
// Purpose: AXI4-Lite slave front end for the 8-bit register file
// Assumes: one write and one read outstanding at most
// Notes: write strobe pulses in the cycle both address and data are held, one cycle after the last handshake
`timescale 1ns/10ps
`default_nettype none
module dslc_axil_slave
    import dslc_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire dslc_axil_req_s axil_req,
    output dslc_axil_rsp_s axil_rsp,
    output dslc_reg_req_s reg_req,
    input wire logic wr_hit,
    input wire logic rd_hit,
    input wire logic [REG_W-1:0] rd_data
);

    logic awready_q, wready_q, aw_held_q, w_held_q, bvalid_q;
    logic arready_q, rd_pend_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [ADDR_W-1:0] awaddr_q, araddr_q;
    logic [REG_W-1:0] wdata_q;
    logic wlane_q;
    logic [DATA_W-1:0] rdata_q;
    logic do_write;

    // ================
    // write channels
    assign do_write = aw_held_q && w_held_q && !bvalid_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            awaddr_q <= '0;
            wdata_q <= '0;
            wlane_q <= 1'b0;
        end else begin
            if (axil_req.awvalid && awready_q) begin
                awready_q <= 1'b0;
                aw_held_q <= 1'b1;
                awaddr_q <= axil_req.awaddr;
            end
            if (axil_req.wvalid && wready_q) begin
                wready_q <= 1'b0;
                w_held_q <= 1'b1;
                wdata_q <= axil_req.wdata[REG_W-1:0];
                wlane_q <= axil_req.wstrb[0];
            end
            if (do_write) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid_q && axil_req.bready) begin
                bvalid_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    // ================
    // read channels
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            arready_q <= 1'b1;
            rd_pend_q <= 1'b0;
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            araddr_q <= '0;
            rdata_q <= '0;
        end else begin
            if (axil_req.arvalid && arready_q) begin
                arready_q <= 1'b0;
                rd_pend_q <= 1'b1;
                araddr_q <= axil_req.araddr;
            end
            if (rd_pend_q) begin
                rd_pend_q <= 1'b0;
                rvalid_q <= 1'b1;
                rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
                rdata_q <= {{(DATA_W-REG_W){1'b0}}, rd_data};
            end
            if (rvalid_q && axil_req.rready) begin
                rvalid_q <= 1'b0;
                arready_q <= 1'b1;
            end
        end
    end

    // lane 0 carries the whole register; a write without it changes nothing
    assign reg_req.wr_en = do_write && wlane_q;
    assign reg_req.wr_idx = awaddr_q[ADDR_W-1:2];
    assign reg_req.wr_data = wdata_q;
    assign reg_req.rd_idx = araddr_q[ADDR_W-1:2];

    assign axil_rsp.awready = awready_q;
    assign axil_rsp.wready = wready_q;
    assign axil_rsp.bresp = bresp_q;
    assign axil_rsp.bvalid = bvalid_q;
    assign axil_rsp.arready = arready_q;
    assign axil_rsp.rdata = rdata_q;
    assign axil_rsp.rresp = rresp_q;
    assign axil_rsp.rvalid = rvalid_q;

endmodule
`default_nettype wire

// file: dslc_top.sv
// Purpose: dither, sample lsb and serial link control registers
// Assumes: samples arrive on clk SAMPLE_LAT cycles after the analog edge they carry
// Notes: timestamp and sysref are pins and pass a two-stage synchroniser
`timescale 1ns/10ps
`default_nettype none
// Contract
// [R1] rounding error select steers dither error
// [R2] amplitude bit: 0 small, 1 large
// [R3] dither applied only while enable set
// [R4] timestamp rides sample lsb when enabled
// [R5] timestamp delayed to match sample latency
// [R6] software also enables timestamp receiver
// [R7] control bit at lsb of wider field
// [R8] lane alignment reports zero control bits
// [R9] link disabled: reset, powered down, gated
// [R10] disabled multiframe counter ignores sysref
// [R11] software disables link before reconfiguring
// [R12] calibration enable brackets link enable
// [R13] mode changes only with both disabled
// [R14] reserved bits written with reset value
// [R15] frames per multiframe resets to 0x1F
// [R16] narrow coding: frames equal register plus one
// [R17] wide coding: frames equal 256*E/F
// [R18] link config applies on next enable
module dslc_top
    import dslc_pkg::*;
#(
    parameter int unsigned NUM_CH = 4,
    parameter int unsigned ADC_W = 12,
    parameter int unsigned LINK_W = 16,
    parameter int unsigned SAMPLE_LAT = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire dslc_axil_req_s s_axil_req,
    output dslc_axil_rsp_s s_axil_rsp,
    input wire logic [NUM_CH-1:0][ADC_W-1:0] sample_in,
    input wire logic sample_in_valid,
    input wire logic timestamp_pin,
    input wire logic sysref_pin,
    input wire logic ila_active,
    output logic dither_enable_q,
    output logic dither_amplitude_select_q,
    output logic rounding_error_select_q,
    output logic cal_enable_q,
    output logic timestamp_receiver_enable_q,
    output logic link_reset_q,
    output logic serializer_powerdown_q,
    output logic link_clock_enable_q,
    output logic [MODE_W-1:0] link_output_mode_q,
    output logic [K_W-1:0] frames_per_multiframe_q,
    output logic lmfc_pulse_q,
    output logic [NUM_CH-1:0][LINK_W-1:0] sample_out_q,
    output logic sample_out_valid_q,
    output logic control_bits_per_sample_q
);

    localparam int unsigned TS_DEPTH = (SAMPLE_LAT > SYNC_STAGES) ?
        SAMPLE_LAT - SYNC_STAGES : 0;

    dslc_reg_req_s reg_req;
    logic wr_hit, rd_hit;
    logic [REG_W-1:0] rd_data;

    logic [2:0] dither_reg_q;
    logic timestamp_insert_enable_q;
    logic serial_link_enable_q;
    logic [MODE_W-1:0] serial_link_output_mode_q;
    logic [7:0] frames_per_multiframe_less_one_q;
    logic link_enable_prev_q;
    logic [MODE_W-1:0] active_mode_q;
    logic [7:0] active_km1_q;
    logic wide_code;
    logic [K_W-1:0] k_eff;
    logic [K_W-1:0] lmfc_cnt_q;

    logic ts_sync1_q, ts_sync2_q, ts_aligned;
    logic sr_sync1_q, sr_sync2_q, sr_prev_q, sysref_rise;

    // ================
    // bus front end
    dslc_axil_slave u_bus (
        .clk(clk),
        .sys_rst(sys_rst),
        .axil_req(s_axil_req),
        .axil_rsp(s_axil_rsp),
        .reg_req(reg_req),
        .wr_hit(wr_hit),
        .rd_hit(rd_hit),
        .rd_data(rd_data)
    );

    function automatic logic idx_mapped(input logic [IDX_W-1:0] idx);
        return (idx == IDX_DITHER_CONTROL) || (idx == IDX_SAMPLE_LSB_CONTROL) ||
            (idx == IDX_SERIAL_LINK_ENABLE) || (idx == IDX_SERIAL_LINK_OUTPUT_MODE) ||
            (idx == IDX_FRAMES_PER_MULTIFRAME_LESS_ONE) ||
            (idx == IDX_SUPPORT_CONTROL) || (idx == IDX_LINK_STATUS);
    endfunction

    assign wr_hit = idx_mapped(reg_req.wr_idx) && (reg_req.wr_idx != IDX_LINK_STATUS);
    assign rd_hit = idx_mapped(reg_req.rd_idx);

    // ================
    // register writes
    // [R14] reserved bits not stored
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dither_reg_q <= RST_DITHER_CONTROL;
            timestamp_insert_enable_q <= RST_TIMESTAMP_INSERT_ENABLE;
            serial_link_enable_q <= RST_SERIAL_LINK_ENABLE;
            serial_link_output_mode_q <= RST_SERIAL_LINK_OUTPUT_MODE;
            // [R15] multiframe reset value
            frames_per_multiframe_less_one_q <= RST_FRAMES_PER_MULTIFRAME_LESS_ONE;
            cal_enable_q <= RST_CAL_ENABLE;
            timestamp_receiver_enable_q <= RST_TIMESTAMP_RECEIVER_ENABLE;
        end else if (reg_req.wr_en) begin
            unique case (reg_req.wr_idx)
                IDX_DITHER_CONTROL: begin
                    dither_reg_q <= reg_req.wr_data[2:0];
                end
                IDX_SAMPLE_LSB_CONTROL: begin
                    timestamp_insert_enable_q <= reg_req.wr_data[BIT_TIMESTAMP_INSERT_ENABLE];
                end
                IDX_SERIAL_LINK_ENABLE: begin
                    serial_link_enable_q <= reg_req.wr_data[BIT_SERIAL_LINK_ENABLE];
                end
                IDX_SERIAL_LINK_OUTPUT_MODE: begin
                    serial_link_output_mode_q <= reg_req.wr_data[MODE_W-1:0];
                end
                IDX_FRAMES_PER_MULTIFRAME_LESS_ONE: begin
                    frames_per_multiframe_less_one_q <= reg_req.wr_data;
                end
                IDX_SUPPORT_CONTROL: begin
                    cal_enable_q <= reg_req.wr_data[BIT_CAL_ENABLE];
                    timestamp_receiver_enable_q <=
                        reg_req.wr_data[BIT_TIMESTAMP_RECEIVER_ENABLE];
                end
                default: begin
                end
            endcase
        end
    end

    // ================
    // register reads
    always_comb begin
        rd_data = '0;
        unique case (reg_req.rd_idx)
            IDX_DITHER_CONTROL: begin
                rd_data[2:0] = dither_reg_q;
            end
            IDX_SAMPLE_LSB_CONTROL: begin
                rd_data[BIT_TIMESTAMP_INSERT_ENABLE] = timestamp_insert_enable_q;
            end
            IDX_SERIAL_LINK_ENABLE: begin
                rd_data[BIT_SERIAL_LINK_ENABLE] = serial_link_enable_q;
            end
            IDX_SERIAL_LINK_OUTPUT_MODE: begin
                rd_data[MODE_W-1:0] = serial_link_output_mode_q;
            end
            IDX_FRAMES_PER_MULTIFRAME_LESS_ONE: begin
                rd_data = frames_per_multiframe_less_one_q;
            end
            IDX_SUPPORT_CONTROL: begin
                rd_data[BIT_CAL_ENABLE] = cal_enable_q;
                rd_data[BIT_TIMESTAMP_RECEIVER_ENABLE] = timestamp_receiver_enable_q;
            end
            IDX_LINK_STATUS: begin
                rd_data[BIT_STAT_RUNNING] = !link_reset_q;
                rd_data[BIT_STAT_WIDE_CODE] = wide_code;
                rd_data[REG_W-1:2] = active_mode_q;
            end
            default: begin
            end
        endcase
    end

    // ================
    // dither controls
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dither_enable_q <= 1'b0;
            dither_amplitude_select_q <= 1'b0;
            rounding_error_select_q <= 1'b0;
        end else begin
            // [R3] dither gated by enable
            dither_enable_q <= dither_reg_q[BIT_DITHER_ENABLE];
            // [R2] small or large amplitude
            dither_amplitude_select_q <= dither_reg_q[BIT_DITHER_AMPLITUDE_SELECT];
            // [R1] error into noise or offset
            rounding_error_select_q <= dither_reg_q[BIT_ROUNDING_ERROR_SELECT];
        end
    end

    // ================
    // link enable and configuration capture
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            link_enable_prev_q <= RST_SERIAL_LINK_ENABLE;
            active_mode_q <= RST_SERIAL_LINK_OUTPUT_MODE;
            active_km1_q <= RST_FRAMES_PER_MULTIFRAME_LESS_ONE;
        end else begin
            link_enable_prev_q <= serial_link_enable_q;
            // [R18] capture on enable rising
            if (serial_link_enable_q && !link_enable_prev_q) begin
                active_mode_q <= serial_link_output_mode_q;
                active_km1_q <= frames_per_multiframe_less_one_q;
            end
        end
    end

    // [R9] reset, power down, gate
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            link_reset_q <= 1'b1;
            serializer_powerdown_q <= 1'b1;
            link_clock_enable_q <= 1'b0;
        end else begin
            link_reset_q <= !link_enable_prev_q;
            serializer_powerdown_q <= !link_enable_prev_q;
            link_clock_enable_q <= link_enable_prev_q;
        end
    end

    // ================
    // multiframe length
    assign wide_code = (active_mode_q >= MODE_WIDE_CODE_FIRST);

    // [R16] narrow: register plus one
    // [R17] wide: 256*E/F, E one, F from mode
    assign k_eff = wide_code ? (WIDE_K_BASE >> active_mode_q[1:0]) :
        (K_W'(active_km1_q) + K_W'(1));

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            link_output_mode_q <= RST_SERIAL_LINK_OUTPUT_MODE;
            frames_per_multiframe_q <= K_W'(RST_FRAMES_PER_MULTIFRAME_LESS_ONE) + K_W'(1);
        end else begin
            link_output_mode_q <= active_mode_q;
            frames_per_multiframe_q <= k_eff;
        end
    end

    // ================
    // pin synchronisers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ts_sync1_q <= 1'b0;
            ts_sync2_q <= 1'b0;
            sr_sync1_q <= 1'b0;
            sr_sync2_q <= 1'b0;
            sr_prev_q <= 1'b0;
        end else begin
            ts_sync1_q <= timestamp_pin;
            ts_sync2_q <= ts_sync1_q;
            sr_sync1_q <= sysref_pin;
            sr_sync2_q <= sr_sync1_q;
            sr_prev_q <= sr_sync2_q;
        end
    end

    assign sysref_rise = sr_sync2_q && !sr_prev_q;

    // ================
    // multiframe counter
    // [R10] held in reset, sysref ignored
    always_ff @(posedge clk) begin
        if (sys_rst || !link_enable_prev_q) begin
            lmfc_cnt_q <= '0;
            lmfc_pulse_q <= 1'b0;
        end else if (sysref_rise) begin
            lmfc_cnt_q <= '0;
            lmfc_pulse_q <= 1'b1;
        end else if (lmfc_cnt_q >= k_eff - K_W'(1)) begin
            lmfc_cnt_q <= '0;
            lmfc_pulse_q <= 1'b1;
        end else begin
            lmfc_cnt_q <= lmfc_cnt_q + K_W'(1);
            lmfc_pulse_q <= 1'b0;
        end
    end

    // ================
    // timestamp path
    // [R5] sync stages plus delay equal sample latency
    dslc_ts_delay #(
        .DEPTH(TS_DEPTH),
        .WIDTH(1)
    ) u_ts_delay (
        .clk(clk),
        .sys_rst(sys_rst),
        .din(ts_sync2_q),
        .dout(ts_aligned)
    );

    // ================
    // sample packing
    // samples stop while the link is held in reset, nothing is buffered
    always_ff @(posedge clk) begin
        if (sys_rst || !link_enable_prev_q) begin
            sample_out_valid_q <= 1'b0;
        end else begin
            sample_out_valid_q <= sample_in_valid;
        end
    end

    generate
        for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
            logic [LINK_W-1:0] field;
            always_comb begin
                field = '0;
                field[LINK_W-1 -: ADC_W] = sample_in[ch];
                // [R4] timestamp on sample lsb
                // [R7] lsb of field, data kept when wider
                if (timestamp_insert_enable_q) begin
                    field[0] = ts_aligned;
                end
            end
            always_ff @(posedge clk) begin
                if (sys_rst || !link_enable_prev_q) begin
                    sample_out_q[ch] <= '0;
                end else if (sample_in_valid) begin
                    sample_out_q[ch] <= field;
                end
            end
        end
    endgenerate

    // [R8] lane alignment advertises zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            control_bits_per_sample_q <= 1'b0;
        end else begin
            control_bits_per_sample_q <= ila_active ? 1'b0 : timestamp_insert_enable_q;
        end
    end

endmodule
`default_nettype wire

// file: dslc_chk.sv
// Purpose: port checks for dslc_top
// Assumes: one clock, sync reset, sysref low
// Notes: bound from the testbench top
`timescale 1ns/10ps
`default_nettype none
module dslc_chk
    import dslc_pkg::*;
#(
    parameter int unsigned NUM_CH = 4,
    parameter int unsigned ADC_W = 12,
    parameter int unsigned LINK_W = 16
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [NUM_CH-1:0][ADC_W-1:0] sample_in,
    input wire logic ila_active,
    input wire logic link_reset_q,
    input wire logic serializer_powerdown_q,
    input wire logic link_clock_enable_q,
    input wire logic [MODE_W-1:0] link_output_mode_q,
    input wire logic [K_W-1:0] frames_per_multiframe_q,
    input wire logic lmfc_pulse_q,
    input wire logic [NUM_CH-1:0][LINK_W-1:0] sample_out_q,
    input wire logic sample_out_valid_q,
    input wire logic control_bits_per_sample_q
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // ====================
    // link control and multiframe length
    sequence s_held;
        link_reset_q ##1 link_reset_q;
    endsequence
    a_link_gated: assert property (
        link_reset_q |-> serializer_powerdown_q && !link_clock_enable_q
    ) else $error("link not gated");
    a_lmfc_held: assert property (
        s_held |-> !lmfc_pulse_q
    ) else $error("pulse while held");
    // k must hold off at least 9 frames here
    a_lmfc_gap: assert property (
        lmfc_pulse_q |=> !lmfc_pulse_q [*8]
    ) else $error("pulses too close");
    a_k_reset: assert property (
        $fell(sys_rst) |-> frames_per_multiframe_q == 9'h020
    ) else $error("k reset wrong");
    a_wide_k: assert property (
        !link_reset_q && !$past(link_reset_q) && link_output_mode_q >= MODE_WIDE_CODE_FIRST
        |-> frames_per_multiframe_q == (WIDE_K_BASE >> link_output_mode_q[1:0])
    ) else $error("wide k wrong");
    // ====================
    // sample path
    a_ila_zero: assert property (
        ila_active |=> !control_bits_per_sample_q
    ) else $error("control bit in ila");
    a_data_top: assert property (
        sample_out_valid_q |-> sample_out_q[0][LINK_W-1-:ADC_W] == $past(sample_in[0])
    ) else $error("sample bits lost");
    a_low_zero: assert property (
        sample_out_valid_q |-> sample_out_q[0][LINK_W-ADC_W-1:1] == '0
    ) else $error("pad bits set");
endmodule
`default_nettype wire

// file: testbench.sv
// Purpose: register and sample path test for dslc_top
// Assumes: sysref low, samples always valid
// Notes: link set up only while disabled
`timescale 1ns/10ps
`default_nettype none
module testbench
    import dslc_pkg::*;
;
    localparam int LAT = 8;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic ts = 1'b0;
    logic ila = 1'b0;
    logic [11:0] smp = 12'h0ABC;
    dslc_axil_req_s rq = '0;
    dslc_axil_rsp_s rs;
    logic [2:0] dith;
    logic lr;
    logic [1:0] sup;
    logic cb;
    logic [K_W-1:0] k;
    logic [K_W-1:0] kx;
    logic [3:0][15:0] so;
    int failures = 0;
    int checks_done = 0;
    int n;
    logic [9:0] ix [5] = '{IDX_DITHER_CONTROL, IDX_SAMPLE_LSB_CONTROL, IDX_SERIAL_LINK_ENABLE,
        IDX_SERIAL_LINK_OUTPUT_MODE, IDX_FRAMES_PER_MULTIFRAME_LESS_ONE};
    logic [7:0] rv [5] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h1F};
    always #5 clk = ~clk;
    always @(posedge clk) smp <= smp + 12'h001;
    dslc_top #(.SAMPLE_LAT(LAT)) dslc_top_i (
        .clk(clk), .sys_rst(sys_rst), .s_axil_req(rq), .s_axil_rsp(rs),
        .sample_in({4{smp}}), .sample_in_valid(1'b1), .timestamp_pin(ts),
        .sysref_pin(1'b0), .ila_active(ila), .dither_enable_q(dith[0]),
        .dither_amplitude_select_q(dith[1]), .rounding_error_select_q(dith[2]),
        .cal_enable_q(sup[0]), .timestamp_receiver_enable_q(sup[1]), .link_reset_q(lr),
        .serializer_powerdown_q(), .link_clock_enable_q(), .link_output_mode_q(),
        .frames_per_multiframe_q(k), .lmfc_pulse_q(), .sample_out_q(so),
        .sample_out_valid_q(), .control_bits_per_sample_q(cb)
    );
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic guard(input int c);
        if (c >= 40) begin
            failures++;
            tally_and_finish();
        end
    endtask
    // ====================
    // bus access
    task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic [1:0] r);
        int c;
        @(posedge clk);
        c = 0;
        rq.awaddr <= {a, 2'h0};
        rq.wdata <= {24'h00_0000, d};
        rq.wstrb <= 4'hF;
        rq.awvalid <= 1'b1;
        rq.wvalid <= 1'b1;
        rq.bready <= 1'b1;
        do begin
            @(posedge clk);
            c++;
            if (rs.awready) rq.awvalid <= 1'b0;
            if (rs.wready) rq.wvalid <= 1'b0;
        end while (!rs.bvalid && c < 40);
        guard(c);
        rq.bready <= 1'b0;
        chk(32'(rs.bresp), 32'(r));
    endtask
    task automatic rd_chk(input logic [9:0] a, input logic [7:0] e, input logic [1:0] r);
        int c;
        @(posedge clk);
        c = 0;
        rq.araddr <= {a, 2'h0};
        rq.arvalid <= 1'b1;
        rq.rready <= 1'b1;
        do begin
            @(posedge clk);
            c++;
            if (rs.arready) rq.arvalid <= 1'b0;
        end while (!rs.rvalid && c < 40);
        guard(c);
        rq.rready <= 1'b0;
        chk(rs.rdata, {24'h00_0000, e});
        chk(32'(rs.rresp), 32'(r));
    endtask
    // ====================
    // scenarios
    initial begin
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 5; i++) rd_chk(ix[i], rv[i], RESP_OKAY);
        chk(32'(k), 32'h0000_0020);
        chk(32'(lr), 32'h0000_0000);
        for (int i = 0; i < 8; i++) begin
            wr(IDX_DITHER_CONTROL, 8'(i), RESP_OKAY);
            @(negedge clk);
            chk(32'(dith), 32'(i));
            rd_chk(IDX_DITHER_CONTROL, 8'(i), RESP_OKAY);
        end
        rd_chk(10'h3FF, 8'h00, RESP_SLVERR);
        wr(IDX_LINK_STATUS, 8'h00, RESP_SLVERR);
        wr(IDX_SUPPORT_CONTROL, 8'h03, RESP_OKAY);
        kx = 9'h020;
        for (int m = 0; m < 5; m++) begin
            wr(IDX_SERIAL_LINK_ENABLE, 8'h00, RESP_OKAY);
            repeat (2) @(negedge clk);
            chk(32'(lr), 32'h0000_0001);
            wr(IDX_SUPPORT_CONTROL, 8'h02, RESP_OKAY);
            chk(32'(sup), 32'h0000_0002);
            wr(IDX_SERIAL_LINK_OUTPUT_MODE, (m < 4) ? 8'(16 + m) : 8'h00, RESP_OKAY);
            wr(IDX_FRAMES_PER_MULTIFRAME_LESS_ONE, 8'h0F, RESP_OKAY);
            @(negedge clk);
            chk(32'(k), 32'(kx));
            wr(IDX_SUPPORT_CONTROL, 8'h03, RESP_OKAY);
            wr(IDX_SERIAL_LINK_ENABLE, 8'h01, RESP_OKAY);
            repeat (3) @(negedge clk);
            kx = (m < 4) ? (9'h100 >> m) : 9'h010;
            chk(32'(k), 32'(kx));
            rd_chk(IDX_LINK_STATUS, {6'(m < 4 ? 16 + m : 0), m < 4, 1'b1}, RESP_OKAY);
        end
        wr(IDX_SAMPLE_LSB_CONTROL, 8'h01, RESP_OKAY);
        @(posedge clk);
        ts <= 1'b1;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (so[0][0] !== 1'b1 && n < 40);
        guard(n);
        chk(32'(n), 32'(LAT + 2));
        chk(32'(cb), 32'h0000_0001);
        @(posedge clk);
        ila <= 1'b1;
        repeat (2) @(negedge clk);
        chk(32'(cb), 32'h0000_0000);
        @(posedge clk);
        ila <= 1'b0;
        wr(IDX_SAMPLE_LSB_CONTROL, 8'h00, RESP_OKAY);
        repeat (2) @(negedge clk);
        chk(32'(so[0][0]), 32'h0000_0000);
        tally_and_finish();
    end
endmodule
bind dslc_top dslc_chk #(.NUM_CH(NUM_CH), .ADC_W(ADC_W), .LINK_W(LINK_W)) dslc_chk_i (
    .clk, .sys_rst, .sample_in, .ila_active, .link_reset_q, .serializer_powerdown_q,
    .link_clock_enable_q, .link_output_mode_q, .frames_per_multiframe_q, .lmfc_pulse_q,
    .sample_out_q, .sample_out_valid_q, .control_bits_per_sample_q
);
`default_nettype wire
